// *** sdci_pkg.sv ***
// Purpose: Shared constants, command and power-state types for the SDRAM command interface.
// Assumes: 100 MHz sys_clk; all pin groups reach the core through two-flop synchronisers.
// Notes: Decode of the four strobes is a function so the core and any wrapper agree.
package sdci_pkg;
  // Array geometry: four banks of rows by columns of 32-bit words.
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int MASK_W = 4;
  // Address bit that selects auto precharge or all-bank precharge.
  localparam int PRESEL_BIT = 10;
  // Self-timed precharge duration and its cycle count, rounded up.
  localparam int CLK_PERIOD_NS = 10;
  localparam int PRE_TIME_NS = 20;
  localparam int PRE_CYCLES = (PRE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_CNT_W = 2;
  // Burst length codes on the burstLen port.
  localparam logic [2:0] LEN_1 = 3'h0;
  localparam logic [2:0] LEN_2 = 3'h1;
  localparam logic [2:0] LEN_4 = 3'h2;
  localparam logic [2:0] LEN_8 = 3'h3;
  localparam logic [2:0] LEN_PAGE = 3'h7;

  // Decoded command of one clock edge.
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF,
                            CMD_MODE} sdci_cmd_e;
  // Activity state chosen by the clock-enable input.
  typedef enum logic [2:0] {PWR_RUN, PWR_SUSPEND, PWR_ACT_PD, PWR_PRE_PD,
                            PWR_SELF_REF} sdci_pwr_e;

  // Turns the active-low strobes into a command; a high chip select masks all.
  function automatic sdci_cmd_e sdci_decode(input logic csN, input logic rasN,
                                            input logic casN, input logic weN);
    sdci_cmd_e c;
    c = CMD_NOP;
    if (!csN) begin
      case ({rasN, casN, weN})
        3'b011: c = CMD_ACT;
        3'b101: c = CMD_RD;
        3'b100: c = CMD_WR;
        3'b110: c = CMD_BST;
        3'b010: c = CMD_PRE;
        3'b001: c = CMD_REF;
        3'b000: c = CMD_MODE;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction
endpackage

// *** sdci_sdram.sv ***
// Purpose: Command, burst and clock-enable core of a four-bank synchronous DRAM.
// Assumes: Pins are synchronised here; burst length and order come in as plain ports.
// Notes: Mode-register load is accepted and ignored; refresh needs no array action.
`timescale 1ns/1ns
module sdci_sdram #(
  parameter int ROW_BITS = sdci_pkg::ROW_W,
  parameter int COL_BITS = sdci_pkg::COL_W
) (
  // Clock and synchronous reset
  input wire logic sys_clk,
  input wire logic reset,
  // Command and address pins
  input wire logic cke,
  input wire logic chipSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnN,
  input wire logic [sdci_pkg::BANK_W-1:0] bankSel,
  input wire logic [sdci_pkg::ADDR_W-1:0] addr,
  // Data pins and byte masks
  input wire logic [sdci_pkg::MASK_W-1:0] byteMask,
  input wire logic [sdci_pkg::DATA_W-1:0] dqIn,
  output logic [sdci_pkg::DATA_W-1:0] dqOut,
  output logic [sdci_pkg::MASK_W-1:0] dqOe,
  // Configuration
  input wire logic [2:0] burstLen,
  input wire logic interleave,
  input wire logic automotiveGrade,
  // Status
  output logic [sdci_pkg::NUM_BANKS-1:0] bankOpen,
  output logic burstBusy,
  output sdci_pkg::sdci_pwr_e powerState,
  output logic inputBufEnable
);
  import sdci_pkg::*;

  localparam int IN_W = 5 + BANK_W + ADDR_W + MASK_W + DATA_W;
  localparam int WORDS = NUM_BANKS << (ROW_BITS + COL_BITS);

  // The column and auto-precharge bits share the address pins, so they must not overlap.
  if (COL_BITS < 3 || COL_BITS > PRESEL_BIT || ROW_BITS < 1 || ROW_BITS > ADDR_W) begin : g_chk
    $error("sdci_sdram: unsupported row or column width");
  end

  // array store
  // Storage for all banks; no reset, as real cells power up undefined.
  logic [DATA_W-1:0] mem [WORDS];

  // Two-flop synchronisers for every pin; only the second stage is read.
  logic [IN_W-1:0] pinMeta_reg;
  logic [IN_W-1:0] pinSync_reg;
  logic ckeS, csS, rasS, casS, weS;
  logic [BANK_W-1:0] bankS;
  logic [ADDR_W-1:0] addrS;
  logic [MASK_W-1:0] maskS;
  logic [DATA_W-1:0] dqS;

  // edge capture
  // Every pin crosses on the rising edge together, so a command stays aligned with its data.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
    end else begin
      pinMeta_reg <= {cke, chipSelN, rowStrobeN, colStrobeN, writeEnN, bankSel, addr,
                      byteMask, dqIn};
      pinSync_reg <= pinMeta_reg;
    end
  end
  assign {ckeS, csS, rasS, casS, weS, bankS, addrS, maskS, dqS} = pinSync_reg;

  // strobe decode
  // A high chip select yields no command at all; bursts carry on regardless.
  sdci_cmd_e cmd;
  assign cmd = sdci_decode(csS, rasS, casS, weS);

  // Number of locations in one burst for a length code; reserved codes act as one.
  function automatic logic [COL_BITS:0] burst_locs(input logic [2:0] len);
    case (len)
      LEN_2: return (COL_BITS+1)'(2);
      LEN_4: return (COL_BITS+1)'(4);
      LEN_8: return (COL_BITS+1)'(8);
      LEN_PAGE: return {1'b1, {COL_BITS{1'b0}}};
      default: return (COL_BITS+1)'(1);
    endcase
  endfunction

  // Column of the n-th location; wraps inside the aligned block of the burst length.
  function automatic logic [COL_BITS-1:0] seq_col(input logic [COL_BITS-1:0] start,
      input logic [COL_BITS:0] n, input logic [COL_BITS:0] locs, input logic ilv);
    logic [COL_BITS-1:0] m;
    logic [COL_BITS-1:0] off;
    m = COL_BITS'(locs - 1'b1);
    off = ilv ? (start ^ n[COL_BITS-1:0]) : (start + n[COL_BITS-1:0]);
    return (start & ~m) | (off & m);
  endfunction

  // Control state and its next values.
  sdci_pwr_e pwr_reg, pwr_next;
  logic [NUM_BANKS-1:0] open_reg, open_next;
  logic [ROW_BITS-1:0] row_reg [NUM_BANKS];
  logic [ROW_BITS-1:0] row_next [NUM_BANKS];
  logic [PRE_CNT_W-1:0] pre_reg [NUM_BANKS];
  logic [PRE_CNT_W-1:0] pre_next [NUM_BANKS];
  logic bAct_reg, bAct_next, bWr_reg, bWr_next, bAuto_reg, bAuto_next;
  logic [BANK_W-1:0] bBank_reg, bBank_next;
  logic [COL_BITS-1:0] bStart_reg, bStart_next;
  logic [COL_BITS:0] bCnt_reg, bCnt_next;
  logic rdValid_reg, rdValid_next;
  logic [MASK_W-1:0] maskD1_reg, maskD1_next, dqOe_reg, dqOe_next;
  logic [DATA_W-1:0] rdData_reg, dqOut_reg, dqOut_next;
  logic bufEn_reg, bufEn_next;
  // Per-cycle access request into the array.
  logic running, advance, access, accWrite, newAcc;
  logic [BANK_W-1:0] accBank;
  logic [COL_BITS-1:0] accCol;
  logic [NUM_BANKS-1:0] closeMask;
  logic [COL_BITS:0] locs;
  logic fullPage;

  assign locs = burst_locs(burstLen);
  assign fullPage = (burstLen == LEN_PAGE);
  // clock gate
  // A low sampled clock enable stops command and burst work this edge; precharge timers still count.
  assign running = (pwr_reg == PWR_RUN) && ckeS;
  // output advance
  // Pipeline stops only while a burst is suspended, so power-down drains any read.
  assign advance = running || (pwr_reg != PWR_SUSPEND && !bAct_reg);

  // Next-state logic for banks, bursts, power state and read output.
  always_comb begin
    pwr_next = pwr_reg;
    open_next = open_reg;
    row_next = row_reg;
    pre_next = pre_reg;
    bAct_next = bAct_reg;
    bWr_next = bWr_reg;
    bAuto_next = bAuto_reg;
    bBank_next = bBank_reg;
    bStart_next = bStart_reg;
    bCnt_next = bCnt_reg;
    rdValid_next = rdValid_reg;
    maskD1_next = maskD1_reg;
    dqOut_next = dqOut_reg;
    dqOe_next = dqOe_reg;
    access = 1'b0;
    accWrite = bWr_reg;
    accBank = bBank_reg;
    accCol = seq_col(bStart_reg, bCnt_reg, locs, interleave && !fullPage);
    closeMask = '0;
    newAcc = 1'b0;
    // independent banks
    // Each bank's precharge timer runs on its own, even beside another bank's burst.
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (pre_reg[b] != '0) begin
        pre_next[b] = pre_reg[b] - 1'b1;
      end
    end
    if (running) begin
      // open row needed
      // Column commands to a closed bank are dropped rather than corrupting data.
      newAcc = (cmd == CMD_RD || cmd == CMD_WR) && open_reg[bankS];
      if (newAcc) begin
        // back-to-back columns
        // A new column command cuts any running burst; an auto-precharge one then closes.
        if (bAct_reg && bAuto_reg) begin
          closeMask[bBank_reg] = 1'b1;
        end
        access = 1'b1;
        accWrite = (cmd == CMD_WR);
        accBank = bankS;
        accCol = addrS[COL_BITS-1:0];
        bBank_next = bankS;
        bWr_next = (cmd == CMD_WR);
        bAuto_next = addrS[PRESEL_BIT];
        bStart_next = addrS[COL_BITS-1:0];
        bCnt_next = (COL_BITS+1)'(1);
        bAct_next = (locs != (COL_BITS+1)'(1));
        if (locs == (COL_BITS+1)'(1) && addrS[PRESEL_BIT]) begin
          closeMask[bankS] = 1'b1;
        end
      end else if (cmd == CMD_BST) begin
        bAct_next = 1'b0;
      end else if (bAct_reg) begin
        access = 1'b1;
        bCnt_next = bCnt_reg + 1'b1;
        if (!fullPage && (bCnt_reg + 1'b1) >= locs) begin
          bAct_next = 1'b0;
          if (bAuto_reg) begin
            closeMask[bBank_reg] = 1'b1;
          end
        end
      end
      if (cmd == CMD_ACT && !open_reg[bankS] && pre_reg[bankS] == '0) begin
        open_next[bankS] = 1'b1;
        row_next[bankS] = addrS[ROW_BITS-1:0];
      end
      if (cmd == CMD_PRE) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
          if (addrS[PRESEL_BIT] || b == int'(bankS)) begin
            closeMask[b] = 1'b1;
            if (bAct_reg && !newAcc && b == int'(bBank_reg)) begin
              bAct_next = 1'b0;
            end
          end
        end
      end
    end
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (closeMask[b] && open_reg[b]) begin
        open_next[b] = 1'b0;
        pre_next[b] = PRE_CNT_W'(PRE_CYCLES);
      end
    end
    // enable exit
    // Inside power-down or self refresh any high sample exits, with no command taken.
    case (pwr_reg)
      PWR_RUN: begin
        if (!ckeS) begin
          if (bAct_reg) begin
            pwr_next = PWR_SUSPEND;
          end else if (open_reg != '0) begin
            pwr_next = PWR_ACT_PD;
          end else if (cmd == CMD_REF && !automotiveGrade) begin
            pwr_next = PWR_SELF_REF;
          end else begin
            pwr_next = PWR_PRE_PD;
          end
        end
      end
      default: begin
        if (ckeS) begin
          pwr_next = PWR_RUN;
        end
      end
    endcase
    bufEn_next = (pwr_next == PWR_RUN) || (pwr_next == PWR_SUSPEND);
    // mask ignores select
    // Array read lands one edge later; mask and data meet at the output register.
    if (advance) begin
      rdValid_next = access && !accWrite;
      maskD1_next = maskS;
      dqOut_next = rdData_reg;
      dqOe_next = {MASK_W{rdValid_reg}} & ~maskD1_reg;
    end
  end

  // bursts outlive deselect
  // Registers for all control state; bursts keep stepping when commands are masked.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pwr_reg <= PWR_RUN;
      open_reg <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_reg[b] <= '0;
        pre_reg[b] <= '0;
      end
      bAct_reg <= 1'b0;
      bWr_reg <= 1'b0;
      bAuto_reg <= 1'b0;
      bBank_reg <= '0;
      bStart_reg <= '0;
      bCnt_reg <= '0;
      rdValid_reg <= 1'b0;
      maskD1_reg <= '0;
      dqOut_reg <= '0;
      dqOe_reg <= '0;
      bufEn_reg <= 1'b1;
    end else begin
      pwr_reg <= pwr_next;
      open_reg <= open_next;
      row_reg <= row_next;
      pre_reg <= pre_next;
      bAct_reg <= bAct_next;
      bWr_reg <= bWr_next;
      bAuto_reg <= bAuto_next;
      bBank_reg <= bBank_next;
      bStart_reg <= bStart_next;
      bCnt_reg <= bCnt_next;
      rdValid_reg <= rdValid_next;
      maskD1_reg <= maskD1_next;
      dqOut_reg <= dqOut_next;
      dqOe_reg <= dqOe_next;
      bufEn_reg <= bufEn_next;
    end
  end

  // write byte mask
  // Array port: masked write bytes are left alone; the read word is registered.
  always_ff @(posedge sys_clk) begin
    if (!reset && access && accWrite) begin
      for (int i = 0; i < MASK_W; i++) begin
        if (!maskS[i]) begin
          mem[{accBank, row_reg[accBank], accCol}][8*i +: 8] <= dqS[8*i +: 8];
        end
      end
    end
    if (advance) begin
      rdData_reg <= mem[{accBank, row_reg[accBank], accCol}];
    end
  end

  assign dqOut = dqOut_reg;
  assign dqOe = dqOe_reg;
  assign bankOpen = open_reg;
  assign burstBusy = bAct_reg;
  assign powerState = pwr_reg;
  assign inputBufEnable = bufEn_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // A masked read: column read with any byte masked, then the pipeline keeps moving.
  sequence s_masked_read;
    running && newAcc && !accWrite && maskS != '0 ##1 advance;
  endsequence

  a_act_opens_bank: assert property (running && cmd == CMD_ACT && !open_reg[bankS] &&
      pre_reg[bankS] == '0 |=> open_reg[$past(bankS)] && row_reg[$past(bankS)] ==
      $past(addrS[ROW_BITS-1:0])) else $error("activate did not open the row");
  a_burst_needs_row: assert property ($rose(bAct_reg) |-> $past(open_reg[bankS]))
    else $error("burst started on a closed bank");
  a_burst_ends_len: assert property (running && bAct_reg && !fullPage && !newAcc &&
      cmd != CMD_PRE && bCnt_reg + 1'b1 >= locs |=> !bAct_reg)
    else $error("burst ran past its length");
  a_terminate_stops: assert property (running && cmd == CMD_BST |=> !bAct_reg)
    else $error("terminate left burst running");
  a_auto_pre_close: assert property (running && bAct_reg && bAuto_reg && !fullPage &&
      !newAcc && bCnt_reg + 1'b1 >= locs |=> !open_reg[$past(bBank_reg)] &&
      pre_reg[$past(bBank_reg)] == PRE_CNT_W'(PRE_CYCLES))
    else $error("auto precharge did not close row");
  a_suspend_holds: assert property (pwr_reg == PWR_SUSPEND && !ckeS |=>
      $stable(bCnt_reg) && $stable(dqOut_reg)) else $error("burst moved in suspend");
  a_act_pd_select: assert property (pwr_reg == PWR_RUN && !ckeS && !bAct_reg &&
      open_reg != '0 |=> pwr_reg == PWR_ACT_PD) else $error("wrong low-power state");
  a_buffers_off: assert property (pwr_reg inside {PWR_ACT_PD, PWR_PRE_PD,
      PWR_SELF_REF} |-> !bufEn_reg) else $error("input buffers on in power-down");
  a_no_self_ref_auto: assert property (automotiveGrade |-> ##1
      pwr_reg != PWR_SELF_REF || $past(pwr_reg) == PWR_SELF_REF)
    else $error("self refresh entered on automotive grade");
  a_mask_two_cycles: assert property (s_masked_read |=>
      (dqOe_reg & $past(maskS, 2)) == '0)
    else $error("read mask latency is not two cycles");
endmodule

// *** sdci_ctrl_model.sv ***
// Purpose: Behavioural memory controller that drives the device's command and data pins.
// Assumes: Pins change just after a falling edge, so each rising edge sees them settled.
// Notes: The bench sequences the commands; this model keeps the pin-level manners only.
`timescale 1ns/1ns
module sdci_ctrl_model (
  // Clock from the bench
  input wire logic sys_clk,
  // Clock enable and command strobes
  output logic cke,
  output logic chipSelN,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeEnN,
  // Bank, address, mask and write data
  output logic [sdci_pkg::BANK_W-1:0] bankSel,
  output logic [sdci_pkg::ADDR_W-1:0] addr,
  output logic [sdci_pkg::MASK_W-1:0] byteMask,
  output logic [sdci_pkg::DATA_W-1:0] dqIn
);
  import sdci_pkg::*;
  // Pins start idle with no-operation strobes.
  initial begin
    cke = 1'b1;
    {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h7;
    bankSel = 2'h0;
    addr = 12'h000;
    byteMask = 4'h0;
    dqIn = 32'h0f0f_0f0f;
  end
  // Presents one strobe code with bank, address, mask and data for one cycle.
  task automatic issue(input logic [3:0] code, input logic [1:0] ba, input logic [11:0] a,
                       input logic [3:0] m, input logic [31:0] d);
    @(negedge sys_clk);
    {chipSelN, rowStrobeN, colStrobeN, writeEnN} = code;
    bankSel = ba;
    addr = a;
    byteMask = m;
    dqIn = d;
  endtask
  // Holds no-operation; the released data bus flips each cycle so stale data never
  // passes for a fresh write.
  task automatic idle(input int n);
    repeat (n) begin
      issue(4'h7, 2'h0, 12'h000, 4'h0, ~dqIn);
    end
  endtask
  // Moves clock enable; the device picks its low-power state by itself.
  task automatic setCke(input logic k);
    cke = k;
  endtask
  // refresh on demand
  // With clock enable low at the same edge, all banks closed and no automotive grade, the device takes this as self refresh.
  task automatic refresh();
    issue(4'h1, 2'h0, 12'h000, 4'h0, ~dqIn);
  endtask
endmodule

// *** tb_sdram_command_interface.sv ***
// Purpose: Self-checking bench for the command, burst and clock-enable core.
// Assumes: Pins reach the core two edges late, so read data shows four edges after a pin.
// Notes: A small array is used; only bank 0 columns 4 to 7 carry stored data.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_sdram_command_interface;
  import sdci_pkg::*;
  // Strobe codes as chip select, row, column and write enable.
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_RD = 4'h5;
  localparam logic [3:0] C_WR = 4'h4;
  localparam logic [3:0] C_BST = 4'h6;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_DES = 4'hb;
  // Bench clock, reset and configuration; the scenarios move them as they go.
  logic sys_clk = 1'b0;
  logic reset;
  logic [2:0] burstLen;
  logic interleave;
  logic automotiveGrade;
  // Pins driven by the controller model.
  logic cke;
  logic chipSelN;
  logic rowStrobeN;
  logic colStrobeN;
  logic writeEnN;
  logic [1:0] bankSel;
  logic [11:0] addr;
  logic [3:0] byteMask;
  logic [31:0] dqIn;
  // Device outputs under check.
  logic [3:0] dqOe;
  logic [3:0] bankOpen;
  logic [31:0] dqOut;
  logic burstBusy;
  logic inputBufEnable;
  sdci_pwr_e powerState;
  int failures = 0;
  int n_checks = 0;
  // Write pattern for columns 4 to 7 of bank 0.
  logic [31:0] wd [4] = '{32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888};
  // Half period of 5 ns gives 100 MHz.
  always #5 sys_clk = ~sys_clk;
  sdci_ctrl_model i_ctrl (.sys_clk(sys_clk), .cke(cke), .chipSelN(chipSelN),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN),
    .bankSel(bankSel), .addr(addr), .byteMask(byteMask), .dqIn(dqIn));
  // Small array keeps memory use low; columns used stay below 16.
  sdci_sdram #(.ROW_BITS(2), .COL_BITS(4)) i_dut (.sys_clk(sys_clk), .reset(reset),
    .cke(cke), .chipSelN(chipSelN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .writeEnN(writeEnN), .bankSel(bankSel), .addr(addr), .byteMask(byteMask),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .burstLen(burstLen), .interleave(interleave),
    .automotiveGrade(automotiveGrade), .bankOpen(bankOpen), .burstBusy(burstBusy),
    .powerState(powerState), .inputBufEnable(inputBufEnable));
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Reads one burst from bank 0, compares each beat on unmasked bytes, then the release.
  // The output register loads one edge after the core takes the command, so the first
  // beat shows at the fourth falling edge after the pins carried it.
  task automatic rdChk(input logic [11:0] a, input int len, input logic [3:0] m,
                       input logic [31:0] e [4]);
    logic [31:0] bm;
    bm = {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
    i_ctrl.issue(C_RD, 2'h0, a, m, 32'h0);
    for (int k = 1; k <= len + 4; k++) begin
      i_ctrl.idle(1);
      if (k >= 4 && k < len + 4) begin
        `CHK("dqOut", e[k-4] & bm, dqOut & bm);
        `CHK("dqOe", ~m, dqOe);
      end else if (k == len + 4) begin
        `CHK("dqOe idle", 4'h0, dqOe);
      end
    end
  endtask
  // Opens bank 0, writes a four-beat burst and reads it back in both orders and lengths.
  task automatic t_burst();
    // Row opened before any column access.
    i_ctrl.issue(C_ACT, 2'h0, 12'h001, 4'h0, 32'h0);
    i_ctrl.idle(4);
    `CHK("bankOpen", 4'h1, bankOpen);
    i_ctrl.issue(C_WR, 2'h0, 12'h004, 4'h0, wd[0]);
    for (int j = 1; j < 4; j++) begin
      i_ctrl.issue(C_NOP, 2'h0, 12'h000, 4'h0, wd[j]);
    end
    i_ctrl.idle(4);
    rdChk(12'h005, 4, 4'h0, '{wd[1], wd[2], wd[3], wd[0]});
    interleave = 1'b1;
    rdChk(12'h005, 4, 4'h0, '{wd[1], wd[0], wd[3], wd[2]});
    interleave = 1'b0;
    // Two-location burst wraps inside its aligned pair.
    burstLen = LEN_2;
    rdChk(12'h005, 2, 4'h0, '{wd[1], wd[0], wd[1], wd[0]});
    burstLen = LEN_4;
  endtask
  // Masked write, then back-to-back single reads with a read mask on the first.
  task automatic t_mask();
    burstLen = LEN_1;
    i_ctrl.issue(C_WR, 2'h0, 12'h004, 4'h1, 32'hffff_ffff);
    i_ctrl.idle(4);
    i_ctrl.issue(C_RD, 2'h0, 12'h004, 4'h2, 32'h0);
    i_ctrl.issue(C_RD, 2'h0, 12'h007, 4'h0, 32'h0);
    for (int k = 1; k <= 5; k++) begin
      i_ctrl.idle(1);
      if (k == 3) begin
        `CHK("dqOut masked", 32'hffff_0022, dqOut & 32'hffff_00ff);
        `CHK("dqOe masked", 4'hd, dqOe);
      end else if (k == 4) begin
        `CHK("dqOut next", wd[3], dqOut);
        `CHK("dqOe next", 4'hf, dqOe);
      end else if (k == 5) begin
        `CHK("dqOe end", 4'h0, dqOe);
      end
    end
  endtask
  // Deselected command, overlapped precharge, auto precharge and precharge of all banks.
  task automatic t_banks();
    i_ctrl.issue(C_DES, 2'h1, 12'h000, 4'h0, 32'h0);
    i_ctrl.idle(4);
    `CHK("bankOpen deselect", 4'h1, bankOpen);
    i_ctrl.issue(C_ACT, 2'h1, 12'h002, 4'h0, 32'h0);
    i_ctrl.idle(4);
    `CHK("bankOpen two", 4'h3, bankOpen);
    i_ctrl.issue(C_PRE, 2'h1, 12'h000, 4'h0, 32'h0);
    rdChk(12'h007, 1, 4'h0, '{4{wd[3]}});
    `CHK("bankOpen one", 4'h1, bankOpen);
    rdChk(12'h404, 1, 4'h0, '{4{32'hffff_ff22}});
    i_ctrl.idle(2);
    `CHK("bankOpen auto", 4'h0, bankOpen);
    i_ctrl.issue(C_ACT, 2'h2, 12'h000, 4'h0, 32'h0);
    i_ctrl.issue(C_ACT, 2'h3, 12'h000, 4'h0, 32'h0);
    i_ctrl.idle(4);
    `CHK("bankOpen pair", 4'hc, bankOpen);
    i_ctrl.issue(C_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
    i_ctrl.idle(4);
    `CHK("bankOpen all", 4'h0, bankOpen);
  endtask
  // Leaves a low state by raising clock enable and checks the run state.
  task automatic wake();
    i_ctrl.setCke(1'b1);
    i_ctrl.idle(5);
    `CHK("powerState run", PWR_RUN, powerState);
    `CHK("inputBufEnable on", 1'b1, inputBufEnable);
  endtask
  // Each low-power state chosen by clock enable, then burst terminate.
  task automatic t_power();
    i_ctrl.setCke(1'b0);
    i_ctrl.idle(4);
    `CHK("powerState idle", PWR_PRE_PD, powerState);
    `CHK("inputBufEnable off", 1'b0, inputBufEnable);
    wake();
    i_ctrl.refresh();
    i_ctrl.setCke(1'b0);
    i_ctrl.idle(4);
    `CHK("powerState self", PWR_SELF_REF, powerState);
    wake();
    automotiveGrade = 1'b1;
    i_ctrl.refresh();
    i_ctrl.setCke(1'b0);
    i_ctrl.idle(4);
    `CHK("powerState grade", PWR_PRE_PD, powerState);
    wake();
    automotiveGrade = 1'b0;
    i_ctrl.issue(C_ACT, 2'h0, 12'h001, 4'h0, 32'h0);
    i_ctrl.idle(4);
    i_ctrl.setCke(1'b0);
    i_ctrl.idle(4);
    `CHK("powerState active", PWR_ACT_PD, powerState);
    wake();
    // Page read starts on written columns, so the word frozen by suspend is defined.
    burstLen = LEN_PAGE;
    i_ctrl.issue(C_RD, 2'h0, 12'h004, 4'h0, 32'h0);
    i_ctrl.idle(3);
    i_ctrl.setCke(1'b0);
    i_ctrl.idle(4);
    `CHK("powerState suspend", PWR_SUSPEND, powerState);
    `CHK("burstBusy suspend", 1'b1, burstBusy);
    wake();
    `CHK("burstBusy page", 1'b1, burstBusy);
    i_ctrl.issue(C_BST, 2'h0, 12'h000, 4'h0, 32'h0);
    i_ctrl.idle(4);
    `CHK("burstBusy stop", 1'b0, burstBusy);
  endtask
  // Cuts a hang short well past the expected run of about 175 cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    test_done();
  end
  // Reset for 20 cycles with clock enable high, then the scenarios.
  initial begin
    reset = 1'b1;
    burstLen = LEN_4;
    interleave = 1'b0;
    automotiveGrade = 1'b0;
    repeat (20) @(negedge sys_clk);
    `CHK("dqOe reset", 4'h0, dqOe);
    `CHK("bankOpen reset", 4'h0, bankOpen);
    `CHK("burstBusy reset", 1'b0, burstBusy);
    reset = 1'b0;
    i_ctrl.idle(8);
    `CHK("powerState start", PWR_RUN, powerState);
    t_burst();
    t_mask();
    t_banks();
    t_power();
    test_done();
  end
endmodule
